/* vpic_host.sv */
// Host controller that drives an interrupt unit through its pins
`timescale 1ns/1ps
module vpic_host
    import vpic_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Software port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Device pins
    output logic device_select_n_o,
    output logic write_strobe_n_o,
    output logic read_strobe_n_o,
    output logic irq_acknowledge_n_o,
    output logic register_select_o,
    input wire logic [7:0] data_lines_i,
    output logic [7:0] data_lines_o,
    output logic data_lines_oe_o,
    input wire logic irq_out_i,
    input wire logic master_slave_or_buffer_enable_i,
    output logic master_slave_or_buffer_enable_o,
    output logic master_slave_or_buffer_enable_oe_o,
    input wire logic [2:0] cascade_lines_i
);

    vpic_state_t state_ff;
    vpic_state_t nxt_state;
    logic [1:0] cmd_ff;
    logic sel_ff;
    logic [1:0] nack_ff;
    logic buf_mode_ff;
    logic master_ff;
    logic [7:0] wbyte_ff;
    logic [7:0] rbyte_ff;
    logic [7:0] vec_ff [0:2];
    logic [1:0] ack_idx_ff;
    logic [3:0] cnt_ff;
    logic irq_s1_ff;
    logic irq_s2_ff;
    logic [2:0] cas_s1_ff;
    logic [2:0] cas_s2_ff;
    logic en_s1_ff;
    logic en_s2_ff;
    logic busy_ff;
    logic done_ff;
    logic [1:0] cur_cmd;
    logic ctrl_wr;
    logic seq_end;
    logic pulse_end;
    logic more_acks;

    // Address decode of the software port
    function automatic logic reg_hit(input logic strobe,
        input logic [3:0] addr,
        input logic [3:0] target);
        return strobe && addr == target;
    endfunction

    // Strobe phase of one command kind in a given state
    function automatic logic phase_of(input vpic_state_t st,
        input logic [1:0] cmd,
        input logic [1:0] kind);
        return st == ST_PULSE && cmd == kind;
    endfunction

    // States in which select and host data stand
    function automatic logic in_frame(input vpic_state_t st);
        return st == ST_SETUP || st == ST_PULSE || st == ST_HOLD;
    endfunction

    // Control write is dropped whole while a transfer runs
    assign ctrl_wr = reg_hit(wr_i, addr_i, REG_CTRL) && !busy_ff;
    wire start = ctrl_wr && wdata_i[CTRL_CMD_LSB +: 2] != 2'h0;
    wire last_cnt = cnt_ff == 4'h1;
    assign pulse_end = state_ff == ST_PULSE && last_cnt;
    assign seq_end = state_ff == ST_GAP && nxt_state == ST_IDLE;
    // Stop after nack plus one pulses; code 3 stops at three
    assign more_acks = ack_idx_ff <= nack_ff && ack_idx_ff != 2'h3;
    // Command seen on its starting edge, so select and data lead the strobe
    assign cur_cmd = start ? wdata_i[CTRL_CMD_LSB +: 2] : cmd_ff;

    // Control and data registers; a new command is refused while busy
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cmd_ff <= CTRL_RST[1:0];
            sel_ff <= CTRL_RST[CTRL_SEL_BIT];
            nack_ff <= CTRL_RST[CTRL_NACK_LSB +: 2];
            buf_mode_ff <= CTRL_RST[CTRL_BUF_BIT];
            master_ff <= CTRL_RST[CTRL_MASTER_BIT];
            wbyte_ff <= DATA_RST;
        end else begin
            if (reg_hit(wr_i, addr_i, REG_WDATA)) begin
                wbyte_ff <= wdata_i;
            end
            if (ctrl_wr) begin
                cmd_ff <= wdata_i[CTRL_CMD_LSB +: 2];
                sel_ff <= wdata_i[CTRL_SEL_BIT];
                nack_ff <= wdata_i[CTRL_NACK_LSB +: 2];
                buf_mode_ff <= wdata_i[CTRL_BUF_BIT];
                master_ff <= wdata_i[CTRL_MASTER_BIT];
            end
        end
    end

    // Two-stage synchronisers for the device's returned levels
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_s1_ff <= 1'b0;
            irq_s2_ff <= 1'b0;
            cas_s1_ff <= 3'h0;
            cas_s2_ff <= 3'h0;
            en_s1_ff <= 1'b0;
            en_s2_ff <= 1'b0;
        end else begin
            irq_s1_ff <= irq_out_i;
            irq_s2_ff <= irq_s1_ff;
            cas_s1_ff <= cascade_lines_i;
            cas_s2_ff <= cas_s1_ff;
            en_s1_ff <= master_slave_or_buffer_enable_i;
            en_s2_ff <= en_s1_ff;
        end
    end

    // Sequencer: setup, strobe low, hold, gap
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start) begin
                    nxt_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (last_cnt) begin
                    nxt_state = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (last_cnt) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (last_cnt) begin
                    nxt_state = ST_GAP;
                end
            end
            ST_GAP: begin
                if (last_cnt) begin
                    nxt_state = (cmd_ff == CMD_ACK && more_acks)
                        ? ST_SETUP : ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            if (nxt_state == ST_PULSE && state_ff != ST_PULSE) begin
                cnt_ff <= STROBE_CNT;
            end else if (nxt_state != state_ff) begin
                cnt_ff <= SETUP_CNT;
            end else if (cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end

    // Busy, done and acknowledge pulse count
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            ack_idx_ff <= 2'h0;
        end else begin
            if (start) begin
                busy_ff <= 1'b1;
                ack_idx_ff <= 2'h0;
            end else if (seq_end) begin
                busy_ff <= 1'b0;
            end
            // Set wins over the clear by status read
            if (seq_end) begin
                done_ff <= 1'b1;
            end else if (reg_hit(rd_i, addr_i, REG_STATUS)) begin
                done_ff <= 1'b0;
            end
            if (pulse_end && cmd_ff == CMD_ACK) begin
                ack_idx_ff <= ack_idx_ff + 2'h1;
            end
        end
    end

    // Capture of read data and vector bytes at end of the strobe
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rbyte_ff <= DATA_RST;
            vec_ff[0] <= DATA_RST;
            vec_ff[1] <= DATA_RST;
            vec_ff[2] <= DATA_RST;
        end else if (pulse_end) begin
            if (cmd_ff == CMD_READ) begin
                rbyte_ff <= data_lines_i;
            end
            if (cmd_ff == CMD_ACK) begin
                vec_ff[ack_idx_ff] <= data_lines_i;
            end
        end
    end

    // Pin drivers, all registered
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            device_select_n_o <= 1'b1;
            write_strobe_n_o <= 1'b1;
            read_strobe_n_o <= 1'b1;
            irq_acknowledge_n_o <= 1'b1;
            register_select_o <= 1'b0;
            data_lines_o <= DATA_RST;
            data_lines_oe_o <= 1'b0;
        end else begin
            // Select spans setup to hold for reads and writes so their strobes sit inside it; acknowledge leaves it high
            device_select_n_o <= !(cur_cmd != CMD_ACK
                && in_frame(nxt_state));
            write_strobe_n_o <= !phase_of(nxt_state, cmd_ff,
                CMD_WRITE);
            read_strobe_n_o <= !phase_of(nxt_state, cmd_ff,
                CMD_READ);
            irq_acknowledge_n_o <= !phase_of(nxt_state, cmd_ff,
                CMD_ACK);
            register_select_o <= ctrl_wr ? wdata_i[CTRL_SEL_BIT]
                : sel_ff;
            data_lines_o <= wbyte_ff;
            // Host drives only on writes; released otherwise
            data_lines_oe_o <= cur_cmd == CMD_WRITE
                && in_frame(nxt_state);
        end
    end

    // Mode pin: driven as a strap only outside buffered mode
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            master_slave_or_buffer_enable_o <= 1'b0;
            master_slave_or_buffer_enable_oe_o <= 1'b0;
        end else begin
            master_slave_or_buffer_enable_o <= master_ff;
            master_slave_or_buffer_enable_oe_o <= !buf_mode_ff;
        end
    end

    // Software read port, data the cycle after rd_i
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                REG_CTRL: rdata_o <= {master_ff, buf_mode_ff, nack_ff,
                    1'b0, sel_ff, cmd_ff};
                REG_WDATA: rdata_o <= wbyte_ff;
                REG_STATUS: rdata_o <= {3'h0, cas_s2_ff, done_ff, busy_ff};
                REG_RDATA: rdata_o <= rbyte_ff;
                REG_VEC0: rdata_o <= vec_ff[0];
                REG_VEC1: rdata_o <= vec_ff[1];
                REG_VEC2: rdata_o <= vec_ff[2];
                REG_PINS: rdata_o <= {6'h00, en_s2_ff, irq_s2_ff};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule // vpic_host

/* vpic_pkg.sv */
// Package for the host-side controller of a vectored priority interrupt unit
package vpic_pkg;
    // Controller's own register offsets (software port)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_WDATA = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_RDATA = 4'h3;
    localparam logic [3:0] REG_VEC0 = 4'h4;
    localparam logic [3:0] REG_VEC1 = 4'h5;
    localparam logic [3:0] REG_VEC2 = 4'h6;
    localparam logic [3:0] REG_PINS = 4'h7;
    // Command encodings written to REG_CTRL bits [1:0]
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_READ = 2'h2;
    localparam logic [1:0] CMD_ACK = 2'h3;
    // Control field positions
    localparam int CTRL_CMD_LSB = 0;
    localparam int CTRL_SEL_BIT = 2;
    localparam int CTRL_NACK_LSB = 4;
    localparam int CTRL_BUF_BIT = 6;
    localparam int CTRL_MASTER_BIT = 7;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    // Strobe timing
    localparam int CLK_MHZ = 25;
    localparam int STROBE_NS = 160;
    localparam int SETUP_NS = 40;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
    localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);
    // Sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_PULSE = 5'b00100,
        ST_HOLD = 5'b01000,
        ST_GAP = 5'b10000
    } vpic_state_t;
endpackage

/* vpic_host_monitor.sv */
// Checker of the device pin protocol driven by the host controller
`timescale 1ns/1ps
module vpic_host_monitor (
    // Clock and reset
    input logic clk_i,
    input logic rstn_i,
    // Device pins
    input logic device_select_n_o,
    input logic write_strobe_n_o,
    input logic read_strobe_n_o,
    input logic irq_acknowledge_n_o,
    input logic register_select_o,
    input logic data_lines_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wr_select_a: assert property (
        !write_strobe_n_o |-> !device_select_n_o) else $error("write unsel");
    rd_select_a: assert property (
        !read_strobe_n_o |-> !device_select_n_o) else $error("read unsel");
    ack_deselect_a: assert property (
        !irq_acknowledge_n_o |-> device_select_n_o && write_strobe_n_o
        && read_strobe_n_o) else $error("ack with select or strobe");
    wr_drive_a: assert property (
        !write_strobe_n_o |-> data_lines_oe_o) else $error("write undriven");
    rd_release_a: assert property (
        !read_strobe_n_o |-> !data_lines_oe_o) else $error("read driven");
    wr_width_a: assert property (
        $fell(write_strobe_n_o) |-> (!write_strobe_n_o)[*4]
        ##1 write_strobe_n_o) else $error("write pulse width");
    ack_width_a: assert property (
        $fell(irq_acknowledge_n_o) |-> (!irq_acknowledge_n_o)[*4]
        ##1 irq_acknowledge_n_o) else $error("ack pulse width");
    sel_stable_a: assert property (
        (!read_strobe_n_o || !write_strobe_n_o) |-> $stable(register_select_o))
        else $error("register select moved");
endmodule // vpic_host_monitor
bind vpic_host vpic_host_monitor vpic_host_monitor_inst (.*);

/* vpic_dev_model.sv */
// Behavioural model of the interrupt unit behind the host controller
`timescale 1ns/1ps
module vpic_dev_model (
    // Clock for the released-bus pattern only
    input wire logic clk_i,
    // Host bus pins
    input wire logic cs_n_i,
    input wire logic wr_n_i,
    input wire logic rd_n_i,
    input wire logic ack_n_i,
    input wire logic rsel_i,
    input wire logic [7:0] host_d_i,
    input wire logic host_oe_i,
    output logic [7:0] bus_o,
    // Request and system pins
    input wire logic [7:0] req_i,
    input wire logic en_d_i,
    input wire logic en_oe_i,
    output logic en_o,
    output logic irq_o,
    output logic [2:0] casc_o
);
    logic [7:0] mask_reg = 8'hff;
    logic [7:0] in_service_reg = 8'h00;
    logic [7:0] mode_ff = 8'h00;
    logic [7:0] flt_ff = 8'h3c;
    logic [1:0] n_ff = 2'h0;
    logic [1:0] k_ff = 2'h0;
    logic [2:0] lvl_ff = 3'h7;
    logic [3:0] top, srv;
    logic drv;
    // No pull on the bus, so a released bus keeps changing
    always @(posedge clk_i) flt_ff <= {flt_ff[6:0], ~flt_ff[7]};
    always_comb begin
        top = 4'h7;
        srv = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (req_i[i] && !mask_reg[i]) top = 4'(i);
            if (in_service_reg[i]) srv = 4'(i);
        end
    end
    assign irq_o = |(req_i & ~mask_reg) && (top < srv);
    always @(posedge wr_n_i) if (!cs_n_i) begin
        if (rsel_i) mask_reg <= host_d_i;
        else mode_ff <= host_d_i;
    end
    // Counted on the fall, so the rise out of reset is not a pulse
    always @(negedge ack_n_i) begin
        if (k_ff == 2'h0) begin
            lvl_ff <= top[2:0];
            in_service_reg[top[2:0]] <= 1'b1;
        end
        n_ff <= k_ff;
        k_ff <= (k_ff == 2'h2) ? 2'h0 : k_ff + 2'h1;
    end
    assign drv = (!cs_n_i && !rd_n_i) || !ack_n_i;
    assign bus_o = host_oe_i ? host_d_i : !drv ? flt_ff :
        !ack_n_i ? (n_ff == 2'h0 ? 8'hcd : n_ff == 2'h1 ?
        {3'h2, lvl_ff, 2'h0} : 8'h5a) : rsel_i ? mask_reg : req_i;
    assign en_o = en_oe_i ? en_d_i : drv;
    assign casc_o = en_o ? lvl_ff : flt_ff[2:0];
endmodule // vpic_dev_model

/* vpic_host_tb.sv */
// Self-checking testbench of the interrupt unit host controller
`timescale 1ns/1ps
module vpic_host_tb;
    import vpic_pkg::*;
    logic clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, req = 8'h00, d, rdata_o, dl_o, bus;
    logic cs_n, wr_n, rd_n, ack_n, rsel, dl_oe, irq, en_d, en_oe, en;
    logic [2:0] casc;
    int error_cnt = 0, tests_run = 0;
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    vpic_host vpic_host_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .device_select_n_o(cs_n),
        .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n),
        .irq_acknowledge_n_o(ack_n), .register_select_o(rsel),
        .data_lines_i(bus), .data_lines_o(dl_o), .data_lines_oe_o(dl_oe),
        .irq_out_i(irq), .master_slave_or_buffer_enable_i(en),
        .master_slave_or_buffer_enable_o(en_d),
        .master_slave_or_buffer_enable_oe_o(en_oe), .cascade_lines_i(casc));
    vpic_dev_model vpic_dev_model_inst (.clk_i(clk_i), .cs_n_i(cs_n),
        .wr_n_i(wr_n), .rd_n_i(rd_n), .ack_n_i(ack_n), .rsel_i(rsel),
        .host_d_i(dl_o), .host_oe_i(dl_oe), .bus_o(bus), .req_i(req),
        .en_d_i(en_d), .en_oe_i(en_oe), .en_o(en), .irq_o(irq),
        .casc_o(casc));
    task automatic chk(input string nm, input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, string nm);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
        if (nm != "") chk(nm, d, e);
    endtask
    // Polls done, so each call also clears the sticky flag
    task automatic cmd(input logic [7:0] v);
        wr(REG_CTRL, v);
        for (int i = 0; i < 60; i++) begin
            rd(REG_STATUS, 8'h00, "");
            if (d[1] === 1'b1) return;
        end
        chk("done", d, 8'h02);
    endtask
    // Two-stage sync on irq needs a few edges
    task automatic set_req(input logic [7:0] v, e);
        @(posedge clk_i);
        req <= v;
        repeat (4) @(posedge clk_i);
        rd(REG_PINS, e, "pins");
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(REG_CTRL, CTRL_RST, "ctrl");
        rd(REG_RDATA, DATA_RST, "rdata");
        rd(REG_PINS, 8'h00, "pins");
        wr(REG_WDATA, 8'ha5);
        wr(REG_CTRL, 8'h85);
        cmd(8'h86);
        rd(REG_RDATA, DATA_RST, "refused");
        cmd(8'h86);
        rd(REG_RDATA, 8'ha5, "mask");
        set_req(8'h20, 8'h02);
        set_req(8'h28, 8'h03);
        cmd(8'h82);
        rd(REG_RDATA, 8'h28, "pending");
        cmd(8'ha3);
        rd(REG_VEC0, 8'hcd, "vec0");
        rd(REG_VEC1, 8'h4c, "vec1");
        rd(REG_VEC2, 8'h5a, "vec2");
        rd(REG_STATUS, 8'h0c, "cascade");
        rd(REG_PINS, 8'h02, "served");
        set_req(8'h60, 8'h02);
        set_req(8'h62, 8'h03);
        wr(REG_CTRL, 8'h00);
        set_req(8'h62, 8'h01);
        wr(REG_CTRL, 8'hc0);
        set_req(8'h62, 8'h01);
        rd(4'hc, 8'h00, "unmapped");
        print_verdict();
    end
    initial begin
        #2000000;
        error_cnt++;
        print_verdict();
    end
endmodule // vpic_host_tb
